/* logic/ahi_host_port.sv */
// Notes on behaviour
// - A low hardware reset pin clears the command and control registers.
// - That reset clears status except the pin-following ready and carrier bits, the interrupt bit and a set tx-empty.
// - In level mode direction high during the data strobe reads, low writes.
// - In pulse mode the direction pin is an active-low write pulse like a RAM write enable.
// - The interrupt pin is open drain, released normally and pulled low on an interrupt.
// - The data lines are driven only during selected read cycles.
// - The port is selected only with select-high high, select-low low and chip enable high.
// - Each address strobe fall latches the data strobe level: low gives level, high pulse mode.
// - Register select latches at address strobe fall; level-mode write data at data strobe fall.
// - Select 00 is tx/rx data, 01 programmed reset/status, 10 command, 11 control.
// - A programmed reset clears command bits 4..0 and status bit 2, keeping control.
//
// Design decisions made here: the APB register port and the address map.
module ahi_host_port
  import ahi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Host bus pins
  input  wire logic        hw_reset_n,
  input  wire ahi_bus_s    hostBus,
  input  wire logic [7:0]  hostDataIn,
  output logic      [7:0]  hostDataOut,
  output logic             hostDataOe,
  output logic             irqPinOut,
  output logic             irqPinOe,
  // Serial core side
  input  wire ahi_serial_s serialIn,
  output logic      [7:0]  txByte,
  output logic             txStrobe,
  output logic      [7:0]  cmdReg,
  output logic      [7:0]  ctrlReg,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ------------------------------------------------------------------
  // Strobe edges and chip select
  // ------------------------------------------------------------------
  logic [2:0]       rise;
  logic [2:0]       fall;
  logic             asFall;
  logic             dsFall;
  logic             dsRise;
  logic             rwRise;
  logic             selected;
  logic             levelMode;
  logic [1:0]       regSel;
  ahi_phase_e       phase;
  logic [7:0]       statusReg;
  logic [ST_TXEMPTY:0] statusFlags;
  logic             hostWrite;
  logic             hostRead;
  logic             readActive;
  logic             progReset;
  logic             hwClear;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] evtStatus;
  logic [EVT_W-1:0] evtMask;
  logic             apbWrite;

  ahi_edge #(
    .W (3)
  ) u_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   ({hostBus.readWrite, hostBus.dataStrobe, hostBus.addrStrobe}),
    .rise    (rise),
    .fall    (fall)
  );

  assign asFall   = fall[0];
  assign dsFall   = fall[1];
  assign dsRise   = rise[1];
  assign rwRise   = rise[2];
  assign selected = hostBus.selectHigh & ~hostBus.selectLow & hostBus.chipEnable;
  assign hwClear  = rst | ~hw_reset_n;

  // ------------------------------------------------------------------
  // Mode and address latch
  // ------------------------------------------------------------------
  // Mode only moves at an address strobe fall, so a cycle never changes style midway
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      levelMode <= 1'b1;
      regSel    <= SEL_DATA;
    end else if (asFall) begin
      levelMode <= ~hostBus.dataStrobe;
      regSel    <= hostDataIn[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase <= PH_IDLE;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (hostBus.addrStrobe) begin
            phase <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          if (asFall) begin
            phase <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (hostBus.addrStrobe) begin
            phase <= PH_ADDR;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Read and write enables
  // ------------------------------------------------------------------
  always_comb begin
    if (levelMode) begin
      readActive = selected & hostBus.dataStrobe & hostBus.readWrite;
      hostWrite  = selected & dsFall & ~hostBus.readWrite;
      hostRead   = selected & dsFall & hostBus.readWrite;
    end else begin
      readActive = selected & ~hostBus.dataStrobe;
      hostWrite  = selected & rwRise;
      hostRead   = selected & dsRise;
    end
    // A new address strobe ends the old cycle, so it may not drive the lines
    if (phase != PH_DATA || hostBus.addrStrobe) begin
      readActive = 1'b0;
      hostWrite  = 1'b0;
      hostRead   = 1'b0;
    end
  end

  assign progReset = hostWrite & (regSel == SEL_STATUS) & hw_reset_n;

  // ------------------------------------------------------------------
  // Command, control and transmit data
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (hwClear) begin
      cmdReg <= CMD_RESET;
    end else if (hostWrite && regSel == SEL_CMD) begin
      cmdReg <= hostDataIn;
    end else if (progReset) begin
      cmdReg <= cmdReg & CMD_PRST_KEEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (hwClear) begin
      ctrlReg <= CTRL_RESET;
    end else if (hostWrite && regSel == SEL_CTRL) begin
      ctrlReg <= hostDataIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txByte   <= 8'h00;
      txStrobe <= 1'b0;
    end else begin
      txStrobe <= hostWrite & (regSel == SEL_DATA) & hw_reset_n;
      if (hostWrite && regSel == SEL_DATA) begin
        txByte <= hostDataIn;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------------
  // Hardware events set flags ahead of the host clearing them
  always_ff @(posedge ref_clk) begin
    if (hwClear) begin
      statusFlags[ST_TXEMPTY] <= 1'b1;
      statusFlags[ST_RXFULL]  <= 1'b0;
      statusFlags[ST_OVERRUN] <= 1'b0;
      statusFlags[ST_FRAMING] <= 1'b0;
      statusFlags[ST_PARITY]  <= 1'b0;
    end else begin
      if (serialIn.txTaken) begin
        statusFlags[ST_TXEMPTY] <= 1'b1;
      end else if (hostWrite && regSel == SEL_DATA) begin
        statusFlags[ST_TXEMPTY] <= 1'b0;
      end
      if (serialIn.rxLoad) begin
        statusFlags[ST_RXFULL]               <= 1'b1;
        statusFlags[ST_OVERRUN:ST_PARITY]    <= serialIn.rxErr;
      end else if (hostRead && regSel == SEL_DATA) begin
        statusFlags[ST_RXFULL]               <= 1'b0;
      end else if (progReset) begin
        statusFlags[ST_OVERRUN]              <= 1'b0;
      end
    end
  end

  // Pin-following bits survive reset untouched
  assign statusReg[ST_TXEMPTY:ST_PARITY] = statusFlags;
  assign statusReg[ST_READY]   = ~serialIn.readyN;
  assign statusReg[ST_CARRIER] = ~serialIn.carrierN;
  assign statusReg[ST_IRQ]     = irq;

  // ------------------------------------------------------------------
  // Host read data
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hostDataOut <= 8'h00;
      hostDataOe  <= 1'b0;
    end else begin
      hostDataOe <= readActive;
      if (regSel == SEL_DATA) begin
        hostDataOut <= serialIn.rxByte;
      end else if (regSel == SEL_STATUS) begin
        hostDataOut <= statusReg;
      end else if (regSel == SEL_CMD) begin
        hostDataOut <= cmdReg;
      end else begin
        hostDataOut <= ctrlReg;
      end
    end
  end

  // ------------------------------------------------------------------
  // Events, interrupt and APB
  // ------------------------------------------------------------------
  assign evt[EV_TXWRITE] = txStrobe;
  assign evt[EV_RXREAD]  = hostRead & (regSel == SEL_DATA);
  assign evt[EV_PRST]    = progReset;
  assign evt[EV_MODE]    = asFall & (levelMode == hostBus.dataStrobe);
  assign apbWrite        = psel & penable & pwrite;

  ahi_irq u_irq (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .evt      (evt),
    .wrStatus (apbWrite & (paddr == APB_EVT_STATUS)),
    .wrMask   (apbWrite & (paddr == APB_EVT_MASK)),
    .wdata    (pwdata[EVT_W-1:0]),
    .status   (evtStatus),
    .mask     (evtMask),
    .irq      (irq)
  );

  // Open drain: only ever pull low, release otherwise
  assign irqPinOut = 1'b0;
  assign irqPinOe  = irq;
  assign pready    = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    if (paddr == APB_EVT_STATUS) begin
      prdata = {28'h0, evtStatus};
    end else if (paddr == APB_EVT_MASK) begin
      prdata = {28'h0, evtMask};
    end else if (paddr == APB_PORT_STATE) begin
      prdata = {5'h00, phase, levelMode, statusReg, cmdReg, ctrlReg};
    end else if (paddr == APB_TX_BYTE) begin
      prdata = {24'h0, txByte};
    end else begin
      prdata  = 32'h0;
      pslverr = psel & penable;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_HWRST_REGS: assert property (!hw_reset_n |=> cmdReg == 8'h00 && ctrlReg == 8'h00)
    else $error("command or control not cleared by hardware reset");
  AST_HWRST_STATUS: assert property (!hw_reset_n |=>
      statusReg[ST_TXEMPTY] && !statusReg[ST_RXFULL] && statusReg[ST_OVERRUN:0] == 3'h0)
    else $error("status not at hardware reset value");
  AST_LEVEL_WRITE: assert property (hostWrite && levelMode && regSel == SEL_CMD && hw_reset_n
      |=> cmdReg == $past(hostDataIn))
    else $error("level mode write to command lost");
  AST_PULSE_WRITE: assert property (!levelMode && selected && rwRise && phase == PH_DATA
      && regSel == SEL_CTRL && hw_reset_n |=> ctrlReg == $past(hostDataIn))
    else $error("pulse mode write to control lost");
  AST_IRQ_OD: assert property (irqPinOut == 1'b0 && irqPinOe == |(evtStatus & evtMask))
    else $error("interrupt pin not open drain or wrong level");
  AST_DATA_OE: assert property (hostDataOe |-> $past(selected) && $past(phase) == PH_DATA)
    else $error("data lines driven outside a selected read");
  AST_SELECT: assert property (hostWrite || readActive |-> hostBus.selectHigh
      && !hostBus.selectLow && hostBus.chipEnable)
    else $error("bus cycle taken while not selected");
  AST_MODE_LATCH: assert property (asFall |=> levelMode == !$past(hostBus.dataStrobe))
    else $error("bus mode not latched at address strobe fall");
  AST_ADDR_LATCH: assert property (asFall |=> regSel == $past(hostDataIn[1:0]))
    else $error("register select not latched");
  AST_DECODE: assert property (hostWrite && regSel == SEL_DATA && hw_reset_n
      |=> txStrobe && txByte == $past(hostDataIn) ##1 !txStrobe)
    else $error("transmit data write not decoded");
  AST_PROG_RESET: assert property (progReset && !serialIn.rxLoad |=> cmdReg[4:0] == 5'h00
      && ctrlReg == $past(ctrlReg) && !statusReg[ST_OVERRUN])
    else $error("programmed reset effect wrong");
  AST_MODE_STABLE: assert property (!asFall |=> $stable(levelMode))
    else $error("bus mode changed outside address strobe fall");

  COV_LEVEL_READ: cover property (levelMode && hostRead);
  COV_PULSE_WRITE: cover property (!levelMode && hostWrite);
  COV_PROG_RESET: cover property (progReset);
  COV_IRQ: cover property (irqPinOe ##1 !irqPinOe);

endmodule : ahi_host_port

/* logic/ahi_pkg.sv */
package ahi_pkg;

  // ------------------------------------------------------------------
  // Host register select codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SEL_DATA   = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_CMD    = 2'h2;
  localparam logic [1:0] SEL_CTRL   = 2'h3;

  // ------------------------------------------------------------------
  // Status register bit positions, command and control reset values
  // ------------------------------------------------------------------
  localparam int ST_PARITY  = 0;
  localparam int ST_FRAMING = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_RXFULL  = 3;
  localparam int ST_TXEMPTY = 4;
  localparam int ST_CARRIER = 5;
  localparam int ST_READY   = 6;
  localparam int ST_IRQ     = 7;
  localparam logic [7:0] CMD_RESET     = 8'h00;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CMD_PRST_KEEP = 8'he0;

  // ------------------------------------------------------------------
  // Event bits and APB map
  // ------------------------------------------------------------------
  localparam int EVT_W       = 4;
  localparam int EV_TXWRITE  = 0;
  localparam int EV_RXREAD   = 1;
  localparam int EV_PRST     = 2;
  localparam int EV_MODE     = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  localparam logic [7:0] APB_EVT_STATUS = 8'h00;
  localparam logic [7:0] APB_EVT_MASK   = 8'h04;
  localparam logic [7:0] APB_PORT_STATE = 8'h08;
  localparam logic [7:0] APB_TX_BYTE    = 8'h0c;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ADDR  = 2'b01,
    PH_DATA  = 2'b11
  } ahi_phase_e;

  typedef struct packed {
    logic       addrStrobe;
    logic       dataStrobe;
    logic       readWrite;
    logic       selectHigh;
    logic       selectLow;
    logic       chipEnable;
  } ahi_bus_s;

  typedef struct packed {
    logic [7:0] rxByte;
    logic       rxLoad;
    logic [2:0] rxErr;
    logic       txTaken;
    logic       readyN;
    logic       carrierN;
  } ahi_serial_s;

endpackage : ahi_pkg

/* logic/ahi_edge.sv */
module ahi_edge
  import ahi_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  // One detector per strobe
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign rise[i] = level[i] & ~prev[i];
    assign fall[i] = prev[i] & ~level[i];
  end

endmodule : ahi_edge

/* logic/ahi_irq.sv */
module ahi_irq
  import ahi_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [EVT_W-1:0] evt,
  input  wire logic             wrStatus,
  input  wire logic             wrMask,
  input  wire logic [EVT_W-1:0] wdata,
  output logic      [EVT_W-1:0] status,
  output logic      [EVT_W-1:0] mask,
  output logic                  irq
);

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= EVT_RESET;
    end else begin
      status <= (status & ~(wrStatus ? wdata : EVT_RESET)) | evt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask <= EVT_RESET;
    end else if (wrMask) begin
      mask <= wdata;
    end
  end

  assign irq = |(status & mask);

endmodule : ahi_irq

/* bench/ahi_host_model.sv */
module ahi_host_model
  import ahi_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] hostDataOut,
  input  wire logic       hostDataOe,
  output ahi_bus_s        hostBus,
  output logic      [7:0] hostDataIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] hostDrive;
  logic       hostOe;
  logic [7:0] lastLevel;

  // ------------------------------------------------------------------
  // Wire level
  // ------------------------------------------------------------------
  // Released lines flip, so a stale value can never pass for read data
  always_comb begin
    if (hostOe) begin
      hostDataIn = hostDrive;
    end else if (hostDataOe === 1'b1) begin
      hostDataIn = hostDataOut;
    end else begin
      hostDataIn = ~lastLevel;
    end
  end

  always @(posedge ref_clk) begin
    if (hostOe || hostDataOe === 1'b1) begin
      lastLevel <= hostDataIn;
    end
  end

  initial begin
    hostBus   = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    hostDrive = 8'h00;
    hostOe    = 1'b0;
    lastLevel = 8'h00;
  end

  // ------------------------------------------------------------------
  // One multiplexed bus cycle
  // ------------------------------------------------------------------
  task automatic busCycle(input logic pulse, input logic rd, input logic [2:0] cs,
                          input logic [1:0] sel, input logic [7:0] wd,
                          output logic [7:0] rdat, output logic oeSeen);
    rdat = 8'h00;
    oeSeen = 1'b0;
    @(posedge ref_clk);
    hostBus.dataStrobe <= pulse;
    @(posedge ref_clk);
    hostBus.addrStrobe <= 1'b1;
    {hostBus.selectHigh, hostBus.selectLow, hostBus.chipEnable} <= cs;
    hostDrive <= {6'h2a, sel};
    hostOe <= 1'b1;
    @(posedge ref_clk);
    hostBus.addrStrobe <= 1'b0;
    @(posedge ref_clk);
    hostOe <= !rd;
    hostDrive <= wd;
    if (pulse && rd) begin
      hostBus.dataStrobe <= 1'b0;
    end else if (pulse) begin
      hostBus.readWrite <= 1'b0;
    end else begin
      hostBus.dataStrobe <= 1'b1;
      hostBus.readWrite <= rd;
    end
    repeat (4) begin
      @(posedge ref_clk);
      if (hostDataOe === 1'b1) begin
        oeSeen = 1'b1;
        rdat = hostDataOut;
      end
    end
    // Data stays driven across the closing strobe edge
    // Level mode keeps the direction through the strobe fall that takes the data
    hostBus.dataStrobe <= pulse;
    if (pulse) begin
      hostBus.readWrite <= 1'b1;
    end
    @(posedge ref_clk);
    hostOe <= 1'b0;
    hostBus.readWrite <= 1'b1;
    {hostBus.selectHigh, hostBus.selectLow, hostBus.chipEnable} <= 3'b010;
  endtask : busCycle
endmodule : ahi_host_model

/* bench/ahi_host_port_tb.sv */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module ahi_host_port_tb
  import ahi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, rst, hw_reset_n;
  ahi_bus_s    hostBus;
  logic [7:0]  hostDataIn, hostDataOut, txByte, cmdReg, ctrlReg, rdat;
  logic        hostDataOe, irqPinOut, irqPinOe, txStrobe, oeSeen;
  ahi_serial_s serialIn;
  logic        psel, penable, pwrite, pready, pslverr, irq, apbErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, apbData;
  logic [2:0]  badSel [3] = '{3'b001, 3'b111, 3'b100};
  int          failCount, checked, txPulses;

  ahi_host_port i_ahi_host_port (
    .ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n), .hostBus(hostBus),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .serialIn(serialIn), .txByte(txByte),
    .txStrobe(txStrobe), .cmdReg(cmdReg), .ctrlReg(ctrlReg), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  ahi_host_model i_ahi_host_model (
    .ref_clk(ref_clk), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .hostBus(hostBus), .hostDataIn(hostDataIn));

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (txStrobe === 1'b1) begin
      txPulses++;
    end
  end

  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    apbData = prdata;
    apbErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : apb

  task automatic hbus(input logic pulse, input logic rd, input logic [2:0] cs,
                      input logic [1:0] sel, input logic [7:0] wd);
    i_ahi_host_model.busCycle(pulse, rd, cs, sel, wd, rdat, oeSeen);
    @(posedge ref_clk);
    #1;
    `CHK(hostDataOe, 1'b0)
  endtask : hbus

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hw_reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    serialIn = '{8'h96, 1'b0, 3'h4, 1'b0, 1'b0, 1'b1};
    failCount = 0;
    checked = 0;
    txPulses = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    hw_reset_n <= 1'b1;
    apb(1'b0, APB_PORT_STATE, 32'h0);
    `CHK(apbData & 32'h017fffff, 32'h01500000)
    `CHK(hostDataOe, 1'b0)
    `CHK(irqPinOut, 1'b0)
    $display("test reset done");

    hbus(1'b0, 1'b0, 3'b101, SEL_CMD, 8'ha5);
    `CHK(cmdReg, 8'ha5)
    `CHK(oeSeen, 1'b0)
    hbus(1'b0, 1'b0, 3'b101, SEL_CTRL, 8'h3c);
    `CHK(ctrlReg, 8'h3c)
    hbus(1'b0, 1'b1, 3'b101, SEL_CMD, 8'h00);
    `CHK(rdat, 8'ha5)
    hbus(1'b0, 1'b1, 3'b101, SEL_CTRL, 8'h00);
    `CHK(rdat, 8'h3c)
    hbus(1'b0, 1'b0, 3'b101, SEL_DATA, 8'h81);
    `CHK(txByte, 8'h81)
    `CHK(txPulses, 1)
    hbus(1'b0, 1'b1, 3'b101, SEL_STATUS, 8'h00);
    `CHK(rdat & 8'h1c, 8'h00)
    $display("test level mode done");

    apb(1'b1, APB_EVT_MASK, 32'h1);
    `CHK(irq, 1'b1)
    `CHK(irqPinOe, 1'b1)
    apb(1'b1, APB_EVT_MASK, 32'h0);
    `CHK(irq, 1'b0)
    apb(1'b1, APB_EVT_STATUS, 32'h1);
    apb(1'b1, APB_EVT_MASK, 32'h1);
    `CHK(irq, 1'b0)
    apb(1'b0, APB_EVT_STATUS, 32'h0);
    `CHK(apbData, 32'h0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({apbErr, apbData}, {1'b1, 32'h0})
    $display("test interrupt done");

    hbus(1'b1, 1'b0, 3'b101, SEL_CMD, 8'h5a);
    `CHK(cmdReg, 8'h5a)
    hbus(1'b1, 1'b1, 3'b101, SEL_CMD, 8'h00);
    `CHK(rdat, 8'h5a)
    apb(1'b0, APB_PORT_STATE, 32'h0);
    `CHK(apbData[24], 1'b0)
    $display("test pulse mode done");

    @(posedge ref_clk);
    serialIn.rxLoad <= 1'b1;
    serialIn.txTaken <= 1'b1;
    @(posedge ref_clk);
    serialIn.rxLoad <= 1'b0;
    serialIn.txTaken <= 1'b0;
    hbus(1'b1, 1'b1, 3'b101, SEL_STATUS, 8'h00);
    `CHK(rdat & 8'h1c, 8'h1c)
    hbus(1'b1, 1'b0, 3'b101, SEL_STATUS, 8'hff);
    `CHK(cmdReg, 8'h5a & CMD_PRST_KEEP)
    `CHK(ctrlReg, 8'h3c)
    hbus(1'b1, 1'b1, 3'b101, SEL_STATUS, 8'h00);
    `CHK(rdat & 8'h0c, 8'h08)
    hbus(1'b1, 1'b1, 3'b101, SEL_DATA, 8'h00);
    `CHK(rdat, 8'h96)
    apb(1'b0, APB_EVT_STATUS, 32'h0);
    `CHK(apbData, 32'he)
    $display("test programmed reset done");

    for (int i = 0; i < 3; i++) begin
      hbus(1'b0, 1'b0, badSel[i], SEL_CMD, 8'hff);
      `CHK(cmdReg, 8'h5a & CMD_PRST_KEEP)
      hbus(1'b0, 1'b1, badSel[i], SEL_CMD, 8'h00);
      `CHK(oeSeen, 1'b0)
    end
    $display("test deselect done");

    @(posedge ref_clk);
    serialIn.readyN <= 1'b1;
    serialIn.carrierN <= 1'b0;
    hw_reset_n <= 1'b0;
    apb(1'b0, APB_PORT_STATE, 32'h0);
    `CHK(apbData & 32'h007fffff, 32'h00300000)
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    hbus(1'b0, 1'b1, 3'b101, SEL_STATUS, 8'h00);
    `CHK(rdat & 8'h7f, 8'h30)
    $display("test hardware reset done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failCount++;
    close_out();
  end
endmodule : ahi_host_port_tb
